// ---- hw/evstat_params.svh ----
// Constants for the event status collector: offsets, fields, resets.
// Assumes inclusion by bare name from the design file.
`ifndef EVSTAT_PARAMS_SVH
`define EVSTAT_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_EVENT_STATUS   8'h58
`define OFS_EVENT_ENABLE   8'h5C
`define OFS_ORDER_PROBE    8'h64
`define OFS_LEVEL_CFG      8'h68
`define OFS_RX_COUNTDOWN   8'h6C

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define RST_STATUS         32'h0000_0000
`define RST_ENABLE         32'h0000_0000
`define RST_LEVEL_CFG      32'h4800_0000
`define ORDER_PROBE_VALUE  32'h8765_4321
`define STATUS_W1C_MASK    32'h83BB_E7DF
`define STATUS_READ_MASK   32'h83BF_E7DF
`define LEVEL_READ_MASK    32'hFFFF_00FF
`define DROP_CNT_BELOW     32'h7FFF_FFFF
`define DROP_CNT_ABOVE     32'h8000_0000

// ****************************************************************
// Flag positions in the status word
// ****************************************************************
`define B_SW_EVENT     31
`define B_TX_HALTED    25
`define B_RX_HALTED    24
`define B_DROP_HALF    23
`define B_TX_BUF_DONE  21
`define B_RX_COUNT     20
`define B_TIMER_WRAP   19
`define B_XCVR_EVENT   18
`define B_PWR_EVENT    17
`define B_TXQ_OVFL     16
`define B_RX_OVERSIZE  15
`define B_RX_ERROR     14
`define B_TX_ERROR     13
`define B_TXD_OVERRUN  10
`define B_TXD_SPACE    9
`define B_TXQ_FULL     8
`define B_TXQ_LEVEL    7
`define B_RX_DROPPED   6
`define B_RXQ_FULL     4
`define B_RXQ_LEVEL    3

// Field positions in the level and countdown registers
`define F_TXD_LVL      31:24
`define F_TXQ_LVL      23:16
`define F_RXQ_LVL      7:0
`define F_COUNTDOWN    27:16

`endif

// ---- hw/evstat_pkg.sv ----
// Types shared by the event status collector.
// Assumes the params header is on the include path.
`default_nettype none

package evstat_pkg;
	typedef logic [31:0] word_t;
	typedef logic [11:0] count_t;
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'h0,
		RESP_SLVERR = 2'h2
	} resp_t;
endpackage

`default_nettype wire

// ---- hw/interrupt_status_collector.sv ----
// Event status collector with an AXI4-Lite register slave.
// Assumes all event inputs come from logic on I_MCLK.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "evstat_params.svh"

module interrupt_status_collector
	import evstat_pkg::*;
(
	input  wire  logic        I_MCLK,           // 10 MHz clock
	input  wire  logic        I_RSTN,           // Sync reset, low
	// AXI4-Lite slave
	input  wire  logic [7:0]  I_AWADDR,         // Write address
	input  wire  logic        I_AWVALID,        // Write address valid
	output var   logic        O_AWREADY,        // Write address ready
	input  wire  logic [31:0] I_WDATA,          // Write data
	input  wire  logic [3:0]  I_WSTRB,          // Byte strobes
	input  wire  logic        I_WVALID,         // Write data valid
	output var   logic        O_WREADY,         // Write data ready
	output var   logic [1:0]  O_BRESP,          // Write response
	output var   logic        O_BVALID,         // Write response valid
	input  wire  logic        I_BREADY,         // Write response ready
	input  wire  logic [7:0]  I_ARADDR,         // Read address
	input  wire  logic        I_ARVALID,        // Read address valid
	output var   logic        O_ARREADY,        // Read address ready
	output var   logic [31:0] O_RDATA,          // Read data
	output var   logic [1:0]  O_RRESP,          // Read response
	output var   logic        O_RVALID,         // Read data valid
	input  wire  logic        I_RREADY,         // Read data ready
	// Event sources
	input  wire  logic        I_TX_HALT_REQ,    // Transmit halt requested
	input  wire  logic        I_TX_STOPPED,     // Transmitter is idle
	input  wire  logic        I_RX_HALTED,      // Receiver in halted state
	input  wire  logic [31:0] I_DROP_CNT,       // Dropped-frame counter
	input  wire  logic        I_TX_BUF_DONE,    // Marked buffer loaded
	input  wire  logic        I_RX_WORD_READ,   // Word read from rx fifo
	input  wire  logic        I_TIMER_WRAP,     // Timer wrapped to FFFFh
	input  wire  logic        I_XCVR_EVENT,     // Transceiver event level
	input  wire  logic        I_PWR_EVENT,      // Power event detected
	input  wire  logic        I_TXQ_OVFL,       // Tx status fifo overflow
	input  wire  logic        I_RX_OVERSIZE,    // Frame over 2048 bytes
	input  wire  logic        I_RX_ERROR,       // Receiver error
	input  wire  logic        I_TX_ERROR,       // Transmitter error
	input  wire  logic        I_TXD_WRITE,      // Tx data write attempt
	input  wire  logic        I_TXD_FULL,       // Tx data fifo full
	input  wire  logic [7:0]  I_TXD_FREE_BLKS,  // Free space, 64B blocks
	input  wire  logic [7:0]  I_TXQ_USED,       // Tx status words used
	input  wire  logic        I_TXQ_FULL,       // Tx status fifo full
	input  wire  logic        I_RX_DROPPED,     // Received frame dropped
	input  wire  logic [7:0]  I_RXQ_USED,       // Rx status words used
	input  wire  logic        I_RXQ_FULL,       // Rx status fifo full
	input  wire  logic [2:0]  I_PIN_EVENT,      // Qualified pin events
	// Results
	output var   logic        O_IRQ_LINE,       // Any enabled flag set
	output var   logic        O_PWR_IRQ,        // Power irq, no hold-off
	output var   logic        O_WAKE,           // Wake pulse
	output var   logic [31:0] O_ENABLE          // Enable mask to irq pin
);

	localparam int LV_TX_HALT = 0;
	localparam int LV_RX_HALT = 1;
	localparam int LV_TXD_SPC = 2;
	localparam int LV_TXQ_LVL = 3;
	localparam int LV_TXQ_FUL = 4;
	localparam int LV_RXQ_FUL = 5;
	localparam int LV_RXQ_LVL = 6;
	localparam int LV_SW_REQ  = 7;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic word_t strobe_mask(input logic [3:0] strb);
		word_t m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	function automatic word_t merge(input word_t old, input word_t wd,
		input logic [3:0] strb);
		word_t m;
		m = strobe_mask(strb);
		return (old & ~m) | (wd & m);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a == `OFS_EVENT_STATUS) || (a == `OFS_EVENT_ENABLE) ||
			(a == `OFS_ORDER_PROBE) || (a == `OFS_LEVEL_CFG) ||
			(a == `OFS_RX_COUNTDOWN);
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	word_t       status_r;
	word_t       status_nxt;
	word_t       enable_r;
	word_t       level_r;
	count_t      countdown_r;
	logic [31:0] drop_prev_r;
	logic [7:0]  lvl_now;
	logic [7:0]  lvl_prev_r;
	logic [7:0]  lvl_rise;
	word_t       ev_set;
	word_t       ev_clr;
	logic        count_done;
	logic [7:0]  aw_addr_r;
	logic        aw_got_r;
	word_t       w_data_r;
	logic [3:0]  w_strb_r;
	logic        w_got_r;
	logic        wr_fire;
	logic [7:0]  rd_addr;
	word_t       rd_word;

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************
	assign wr_fire = aw_got_r && w_got_r && !O_BVALID;

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_AWREADY <= 1'b0;
			aw_got_r  <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (O_AWREADY && I_AWVALID) begin
			O_AWREADY <= 1'b0;
			aw_got_r  <= 1'b1;
			aw_addr_r <= I_AWADDR;
		end else if (wr_fire) begin
			aw_got_r  <= 1'b0;
		end else begin
			O_AWREADY <= !aw_got_r && !O_BVALID;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_WREADY <= 1'b0;
			w_got_r  <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (O_WREADY && I_WVALID) begin
			O_WREADY <= 1'b0;
			w_got_r  <= 1'b1;
			w_data_r <= I_WDATA;
			w_strb_r <= I_WSTRB;
		end else if (wr_fire) begin
			w_got_r  <= 1'b0;
		end else begin
			O_WREADY <= !w_got_r && !O_BVALID;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// ****************************************************************
	// AXI4-Lite read channels
	// ****************************************************************
	assign rd_addr = I_ARADDR;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (rd_addr)
			`OFS_EVENT_STATUS: rd_word = status_r & `STATUS_READ_MASK;
			`OFS_EVENT_ENABLE: rd_word = enable_r & `STATUS_READ_MASK;
			`OFS_ORDER_PROBE:  rd_word = `ORDER_PROBE_VALUE;
			`OFS_LEVEL_CFG:    rd_word = level_r & `LEVEL_READ_MASK;
			`OFS_RX_COUNTDOWN: rd_word[`F_COUNTDOWN] = countdown_r;
			default:           rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b0;
			O_RDATA   <= 32'h0000_0000;
			O_RRESP   <= RESP_OKAY;
		end else if (O_ARREADY && I_ARVALID) begin
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b1;
			O_RDATA   <= rd_word;
			O_RRESP   <= mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (O_RVALID) begin
			O_RVALID  <= !I_RREADY;
		end else begin
			O_ARREADY <= 1'b1;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			enable_r <= `RST_ENABLE;
		end else if (wr_fire && aw_addr_r == `OFS_EVENT_ENABLE) begin
			enable_r <= merge(enable_r, w_data_r, w_strb_r)
				& `STATUS_READ_MASK;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			level_r <= `RST_LEVEL_CFG;
		end else if (wr_fire && aw_addr_r == `OFS_LEVEL_CFG) begin
			level_r <= merge(level_r, w_data_r, w_strb_r)
				& `LEVEL_READ_MASK;
		end
	end

	// Countdown of words still to be read from the receive fifo
	assign count_done = I_RX_WORD_READ && (countdown_r == 12'h001);

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			countdown_r <= 12'h000;
		end else if (wr_fire && aw_addr_r == `OFS_RX_COUNTDOWN) begin
			countdown_r <= count_t'(merge({4'h0, countdown_r, 16'h0000},
				w_data_r, w_strb_r) >> 16);
		end else if (I_RX_WORD_READ && countdown_r != 12'h000) begin
			countdown_r <= countdown_r - 12'h001;
		end
	end

	// ****************************************************************
	// Event detection
	// ****************************************************************
	always_comb begin
		lvl_now             = 8'h00;
		lvl_now[LV_TX_HALT] = I_TX_HALT_REQ && I_TX_STOPPED;
		lvl_now[LV_RX_HALT] = I_RX_HALTED;
		lvl_now[LV_TXD_SPC] = I_TXD_FREE_BLKS > level_r[`F_TXD_LVL];
		lvl_now[LV_TXQ_LVL] = I_TXQ_USED > level_r[`F_TXQ_LVL];
		lvl_now[LV_TXQ_FUL] = I_TXQ_FULL;
		lvl_now[LV_RXQ_FUL] = I_RXQ_FULL;
		lvl_now[LV_RXQ_LVL] = I_RXQ_USED > level_r[`F_RXQ_LVL];
		lvl_now[LV_SW_REQ]  = enable_r[`B_SW_EVENT];
	end

	assign lvl_rise = lvl_now & ~lvl_prev_r;

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			lvl_prev_r  <= 8'h00;
			drop_prev_r <= 32'h0000_0000;
		end else begin
			lvl_prev_r  <= lvl_now;
			drop_prev_r <= I_DROP_CNT;
		end
	end

	// Sources set flags regardless of the enable mask, except bit 31, which is set when enable bit 31 rises
	always_comb begin
		ev_set                 = 32'h0000_0000;
		ev_set[`B_SW_EVENT]    = lvl_rise[LV_SW_REQ];
		ev_set[`B_TX_HALTED]   = lvl_rise[LV_TX_HALT];
		ev_set[`B_RX_HALTED]   = lvl_rise[LV_RX_HALT];
		ev_set[`B_DROP_HALF]   = drop_prev_r == `DROP_CNT_BELOW &&
			I_DROP_CNT == `DROP_CNT_ABOVE;
		ev_set[`B_TX_BUF_DONE] = I_TX_BUF_DONE;
		ev_set[`B_RX_COUNT]    = count_done;
		ev_set[`B_TIMER_WRAP]  = I_TIMER_WRAP;
		ev_set[`B_PWR_EVENT]   = I_PWR_EVENT;
		ev_set[`B_TXQ_OVFL]    = I_TXQ_OVFL;
		ev_set[`B_RX_OVERSIZE] = I_RX_OVERSIZE;
		ev_set[`B_RX_ERROR]    = I_RX_ERROR;
		ev_set[`B_TX_ERROR]    = I_TX_ERROR;
		ev_set[`B_TXD_OVERRUN] = I_TXD_WRITE && I_TXD_FULL;
		ev_set[`B_TXD_SPACE]   = lvl_rise[LV_TXD_SPC];
		ev_set[`B_TXQ_FULL]    = lvl_rise[LV_TXQ_FUL];
		ev_set[`B_TXQ_LEVEL]   = lvl_rise[LV_TXQ_LVL];
		ev_set[`B_RX_DROPPED]  = I_RX_DROPPED;
		ev_set[`B_RXQ_FULL]    = lvl_rise[LV_RXQ_FUL];
		ev_set[`B_RXQ_LEVEL]   = lvl_rise[LV_RXQ_LVL];
		ev_set[2:0]            = I_PIN_EVENT;
	end

	// ****************************************************************
	// Status register
	// ****************************************************************
	// Write-one-to-clear; the transceiver bit and reserved bits ignore it
	assign ev_clr = (wr_fire && aw_addr_r == `OFS_EVENT_STATUS) ?
		(w_data_r & strobe_mask(w_strb_r) & `STATUS_W1C_MASK) :
		32'h0000_0000;

	always_comb begin
		status_nxt = ((status_r & ~ev_clr) | ev_set)
			& `STATUS_W1C_MASK;
		status_nxt[`B_XCVR_EVENT] = I_XCVR_EVENT;
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			status_r <= `RST_STATUS;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ****************************************************************
	// Interrupt and wake outputs
	// ****************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_IRQ_LINE <= 1'b0;
			O_PWR_IRQ  <= 1'b0;
			O_ENABLE   <= 32'h0000_0000;
		end else begin
			O_IRQ_LINE <= |(status_r & enable_r);
			O_PWR_IRQ  <= status_r[`B_PWR_EVENT] &&
				enable_r[`B_PWR_EVENT];
			O_ENABLE   <= enable_r;
		end
	end

	// Only a host write to the probe register wakes the device
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_WAKE <= 1'b0;
		end else begin
			O_WAKE <= wr_fire && aw_addr_r == `OFS_ORDER_PROBE;
		end
	end

endmodule

`default_nettype wire

// ---- verif/evstat_chk.sv ----
// Port checker for the event status collector.
// Assumes it is bound onto interrupt_status_collector.
`timescale 1ns/1ps
`default_nettype none

module evstat_chk (
	input wire logic        I_MCLK,      // Clock
	input wire logic        I_RSTN,      // Reset, low
	input wire logic        I_AWVALID,   // Aw valid
	input wire logic        O_AWREADY,   // Aw ready
	input wire logic        I_WVALID,    // W valid
	input wire logic        O_WREADY,    // W ready
	input wire logic        O_BVALID,    // B valid
	input wire logic        I_ARVALID,   // Ar valid
	input wire logic        O_ARREADY,   // Ar ready
	input wire logic        O_RVALID,    // R valid
	input wire logic        I_PWR_EVENT, // Power event
	input wire logic        O_IRQ_LINE,  // Combined line
	input wire logic        O_PWR_IRQ,   // Power irq
	input wire logic        O_WAKE,      // Wake pulse
	input wire logic [31:0] O_ENABLE     // Enable copy
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RSTN);

	sequence s_wr_take;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_b_late;
		!O_BVALID ##1 O_BVALID;
	endsequence
	sequence s_pwr_seen;
		I_PWR_EVENT && O_ENABLE[17];
	endsequence

	property p_b_time;
		s_wr_take |=> s_b_late;
	endproperty
	property p_b_refuse;
		O_BVALID |-> !O_AWREADY && !O_WREADY;
	endproperty
	property p_r_time;
		I_ARVALID && O_ARREADY |=> O_RVALID;
	endproperty
	property p_r_refuse;
		O_RVALID |-> !O_ARREADY;
	endproperty
	property p_pwr_en;
		O_PWR_IRQ |-> O_ENABLE[17];
	endproperty
	property p_pwr_line;
		O_PWR_IRQ |-> O_IRQ_LINE;
	endproperty
	property p_pwr_evt;
		s_pwr_seen |-> ##2 (O_PWR_IRQ || !O_ENABLE[17]);
	endproperty
	property p_line_en;
		O_IRQ_LINE |-> (O_ENABLE != 32'h0);
	endproperty
	property p_wake;
		O_WAKE |=> !O_WAKE;
	endproperty

	a_b_time: assert property (p_b_time)
		else $error("write answer not on time");
	a_b_refuse: assert property (p_b_refuse)
		else $error("write ready during answer");
	a_r_time: assert property (p_r_time)
		else $error("read answer not on time");
	a_r_refuse: assert property (p_r_refuse)
		else $error("read ready during answer");
	a_pwr_en: assert property (p_pwr_en)
		else $error("power irq without enable");
	a_pwr_line: assert property (p_pwr_line)
		else $error("power irq missing on line");
	a_pwr_evt: assert property (p_pwr_evt)
		else $error("power irq late");
	a_line_en: assert property (p_line_en)
		else $error("line high with no enable");
	a_wake: assert property (p_wake)
		else $error("wake longer than a cycle");
endmodule

bind interrupt_status_collector evstat_chk evstat_chk_inst (
	.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_AWVALID(I_AWVALID),
	.O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
	.O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
	.O_RVALID(O_RVALID), .I_PWR_EVENT(I_PWR_EVENT),
	.O_IRQ_LINE(O_IRQ_LINE), .O_PWR_IRQ(O_PWR_IRQ), .O_WAKE(O_WAKE),
	.O_ENABLE(O_ENABLE)
);

`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the event status collector.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench import evstat_pkg::*;;
	localparam logic [7:0] ST = 8'h58, EN = 8'h5C, PR = 8'h64;
	localparam logic [7:0] CD = 8'h6C, LV = 8'h68;
	localparam word_t      PM = 32'h032B_E557;
	logic        clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0;
	logic        brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic        stopped = 1'b1, full = 1'b1;
	logic [7:0]  awa = 8'h0, ara = 8'h0, free = 8'h0;
	logic [7:0]  tqu = 8'h0, rqu = 8'h0;
	logic [3:0]  strb = 4'h0;
	word_t       wd = 32'h0, evp = 32'h0, drop = 32'h0;
	logic        awr, wrdy, bv, arr, rv, irq, pirq, wake;
	logic [1:0]  br, rr;
	word_t       rdat, en;
	int          fails = 0, samples_checked = 0, wakes = 0;

	interrupt_status_collector interrupt_status_collector_inst (
		.I_MCLK(clk), .I_RSTN(rstn), .I_AWADDR(awa), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(strb), .I_WVALID(wv),
		.O_WREADY(wrdy), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(brdy),
		.I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat),
		.O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rrdy),
		.I_TX_HALT_REQ(evp[25]), .I_TX_STOPPED(stopped),
		.I_RX_HALTED(evp[24]), .I_DROP_CNT(drop),
		.I_TX_BUF_DONE(evp[21]), .I_RX_WORD_READ(evp[20]),
		.I_TIMER_WRAP(evp[19]), .I_XCVR_EVENT(evp[18]),
		.I_PWR_EVENT(evp[17]), .I_TXQ_OVFL(evp[16]),
		.I_RX_OVERSIZE(evp[15]), .I_RX_ERROR(evp[14]),
		.I_TX_ERROR(evp[13]), .I_TXD_WRITE(evp[10]), .I_TXD_FULL(full),
		.I_TXD_FREE_BLKS(free), .I_TXQ_USED(tqu), .I_TXQ_FULL(evp[8]),
		.I_RX_DROPPED(evp[6]), .I_RXQ_USED(rqu), .I_RXQ_FULL(evp[4]),
		.I_PIN_EVENT(evp[2:0]), .O_IRQ_LINE(irq), .O_PWR_IRQ(pirq),
		.O_WAKE(wake), .O_ENABLE(en)
	);

	// ****************************************
	// Clock, monitors and bus tasks
	// ****************************************
	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wake === 1'b1)
			wakes++;
	end

	task automatic close_out;
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input word_t got, input word_t exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic pl(input word_t m);
		@(posedge clk);
		evp <= m;
		@(posedge clk);
		evp <= 32'h0;
	endtask

	task automatic wr(input logic [7:0] a, input word_t d,
			input logic [3:0] s = 4'hF, input logic [1:0] e = 2'h0);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awv && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wrdy) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
		end while (!bv);
		brdy <= 1'b0;
		chk(32'(br), 32'(e));
	endtask

	task automatic rd(input logic [7:0] a, input word_t x,
			input logic [1:0] e = 2'h0);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(posedge clk);
		end while (!arr);
		arv <= 1'b0;
		do begin
			@(posedge clk);
		end while (!rv);
		rrdy <= 1'b0;
		chk(rdat, x);
		chk(32'(rr), 32'(e));
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		word_t m;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(ST, 32'h0);
		rd(EN, 32'h0);
		rd(LV, 32'h4800_0000);
		rd(PR, 32'h8765_4321);
		rd(8'h70, 32'h0, 2'h2);
		wr(8'h70, 32'hFFFF_FFFF, 4'hF, 2'h2);
		// Each event flag in PM: set, kept by zeros, cleared by its one
		for (int i = 0; i < 32; i++) begin
			m = 32'h1 << i;
			if (PM[i]) begin
				pl(m);
				rd(ST, m);
				wr(ST, ~m);
				rd(ST, m);
				wr(ST, m);
				rd(ST, 32'h0);
			end
		end
		stopped <= 1'b0;
		full <= 1'b0;
		pl(32'h0200_0400);
		rd(ST, 32'h0);
		drop <= 32'h8000_0000;
		rd(ST, 32'h0);
		drop <= 32'h7FFF_FFFF;
		tick(2);
		drop <= 32'h8000_0000;
		rd(ST, 32'h0080_0000);
		wr(CD, 32'h0002_0000);
		rd(CD, 32'h0002_0000);
		pl(32'h0010_0000);
		rd(ST, 32'h0080_0000);
		pl(32'h0010_0000);
		rd(ST, 32'h0090_0000);
		rd(CD, 32'h0);
		wr(ST, 32'h0090_0000);
		free <= 8'h48;
		tqu <= 8'h01;
		rqu <= 8'h01;
		rd(ST, 32'h0000_0088);
		free <= 8'h49;
		rd(ST, 32'h0000_0288);
		wr(ST, 32'h0000_0288);
		rd(ST, 32'h0);
		wr(EN, 32'h8002_0000);
		rd(ST, 32'h8000_0000);
		rd(EN, 32'h8002_0000);
		chk(en, 32'h8002_0000);
		chk(32'(irq), 32'h1);
		wr(ST, 32'h8000_0000);
		pl(32'h0002_0000);
		tick(2);
		chk(32'(pirq), 32'h1);
		chk(32'(wakes), 32'h0);
		wr(ST, 32'h0002_0000);
		tick(2);
		chk(32'(pirq) + 32'(irq), 32'h0);
		rd(ST, 32'h0);
		wr(EN, 32'h0);
		evp <= 32'h0004_0000;
		rd(ST, 32'h0004_0000);
		wr(ST, 32'h0004_0000);
		rd(ST, 32'h0004_0000);
		evp <= 32'h0;
		pl(32'h0000_2004);
		wr(ST, 32'hFFFF_FFFF, 4'h1);
		rd(ST, 32'h0000_2000);
		wr(PR, 32'h0);
		tick(2);
		chk(32'(wakes), 32'h1);
		rd(PR, 32'h8765_4321);
		wr(LV, 32'hFFFF_FFFF);
		rd(LV, 32'hFFFF_00FF);
		close_out;
	end

	initial begin
		repeat (8000) @(posedge clk);
		fails++;
		close_out;
	end
endmodule

`default_nettype wire
